// ### verilog/fsc_dsp.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
module fsc_dsp
  import fsc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic adc_valid_i,
  output logic adc_ready_o,
  input wire logic [13:0] adc_data_i,
  input wire logic [15:0] temp_delta_i,
  input wire logic [1:0] cmd_i,
  input wire logic [3:0] cmd_addr_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic [15:0] cmd_rdata_o,
  output logic cmd_ack_o,
  output logic [2:0] span_sel_o,
  output logic [11:0] dac_code_o,
  output logic dac_enable_o,
  output logic locked_o
);
  logic [5:0] mode_ff;
  logic [15:0] lin_tc_ff;
  logic [15:0] quad_tc_ff;
  logic [15:0] gain_ff;
  logic [15:0] qol_ff;
  logic [15:0] floor_ff;
  logic [15:0] ceil_ff;
  logic guard_ff;
  logic [13:0] raw_ff;
  logic busy_ff;
  logic fifo_valid;
  logic fifo_ready;
  logic [13:0] fifo_data;
  logic filt_valid;
  logic signed [13:0] filt_data;
  logic signed [15:0] eff_gain_ff;
  logic signed [15:0] nxt_eff_gain;
  logic signed [63:0] tdelta;
  logic signed [63:0] gbase;
  logic signed [63:0] lin_term;
  logic signed [63:0] quad_term;
  logic signed [63:0] gscaled;
  logic signed [31:0] prod_ff;
  logic signed [31:0] sum;
  logic signed [31:0] upper;
  logic signed [31:0] lower;
  logic signed [31:0] nxt_out;
  logic prod_valid_ff;
  logic cmd_take;
  fsc_cmd_t cmd;

  // ==========================================================
  // Helper functions
  function automatic logic signed [31:0] sat_to(
    input logic signed [31:0] v,
    input logic signed [31:0] lo,
    input logic signed [31:0] hi
  );
    logic signed [31:0] r;
    r = v;
    if (v < lo)
      r = lo;
    if (v > hi)
      r = hi;
    return r;
  endfunction

  function automatic logic signed [31:0] sx16(input logic [15:0] v);
    return 32'(signed'(v));
  endfunction

  // ==========================================================
  // Command decode; a sealed part treats every command as absent
  assign cmd = fsc_cmd_t'(cmd_i);
  assign cmd_take = (cmd != FSC_CMD_NONE) && !guard_ff;

  // Parameter registers, rewritable until sealed
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mode_ff <= `FSC_MODE_RST;
      lin_tc_ff <= `FSC_LIN_TC_RST;
      quad_tc_ff <= `FSC_QUAD_TC_RST;
      gain_ff <= `FSC_GAIN_RST;
      qol_ff <= `FSC_QOL_RST;
      floor_ff <= `FSC_FLOOR_RST;
      ceil_ff <= `FSC_CEIL_RST;
    end
    else if (cmd_take && cmd == FSC_CMD_WRITE)
    begin
      unique case (cmd_addr_i)
        `FSC_ADDR_MODE: mode_ff <= cmd_wdata_i[5:0];
        `FSC_ADDR_LIN_TC: lin_tc_ff <= cmd_wdata_i;
        `FSC_ADDR_QUAD_TC: quad_tc_ff <= cmd_wdata_i;
        `FSC_ADDR_GAIN: gain_ff <= cmd_wdata_i;
        `FSC_ADDR_QOL: qol_ff <= cmd_wdata_i;
        // Floor clipped to half supply
        `FSC_ADDR_FLOOR: floor_ff <= (cmd_wdata_i > `FSC_FLOOR_MAX) ?
          `FSC_FLOOR_MAX : cmd_wdata_i;
        // Ceiling held to the output code width
        `FSC_ADDR_CEIL: ceil_ff <= {4'h0, cmd_wdata_i[11:0]};
        default: ;
      endcase
    end
  end

  // Guard bit: set by seal or by a write of one, never cleared
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      guard_ff <= 1'b0;
    else if (cmd_take && (cmd == FSC_CMD_SEAL ||
             (cmd == FSC_CMD_WRITE && cmd_addr_i == `FSC_ADDR_GUARD &&
              cmd_wdata_i[0])))
      guard_ff <= 1'b1;
  end

  // Read answers and exchange state; analog output muted meanwhile
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cmd_rdata_o <= 16'h0000;
      cmd_ack_o <= 1'b0;
      busy_ff <= 1'b0;
    end
    else
    begin
      cmd_ack_o <= cmd_take;
      busy_ff <= cmd_take;
      if (cmd_take && cmd == FSC_CMD_READ)
      begin
        unique case (cmd_addr_i)
          `FSC_ADDR_MODE: cmd_rdata_o <= {10'h000, mode_ff};
          `FSC_ADDR_LIN_TC: cmd_rdata_o <= lin_tc_ff;
          `FSC_ADDR_QUAD_TC: cmd_rdata_o <= quad_tc_ff;
          `FSC_ADDR_GAIN: cmd_rdata_o <= gain_ff;
          `FSC_ADDR_QOL: cmd_rdata_o <= qol_ff;
          `FSC_ADDR_FLOOR: cmd_rdata_o <= floor_ff;
          `FSC_ADDR_CEIL: cmd_rdata_o <= ceil_ff;
          `FSC_ADDR_GUARD: cmd_rdata_o <= {15'h0000, guard_ff};
          `FSC_ADDR_RAW: cmd_rdata_o <= {{2{raw_ff[13]}}, raw_ff};
          default: cmd_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Sample path: buffer, then filter; the filter always drains,
  // so the FIFO only absorbs bursts and its ready is reported late
  fsc_fifo #(
    .WIDTH(14),
    .DEPTH(32)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(adc_valid_i),
    .in_ready_o(fifo_ready),
    .in_data_i(adc_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(1'b1),
    .out_data_o(fifo_data)
  );

  fsc_lowpass u_lowpass (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .corner_i(mode_ff[`FSC_MODE_CORNER_LSB +: 3]),
    .in_valid_i(fifo_valid),
    .in_data_i(signed'(fifo_data)),
    .out_valid_o(filt_valid),
    .out_data_o(filt_data)
  );

  // Filtered value is the raw sample readable by the programmer
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      raw_ff <= 14'h0000;
    else if (filt_valid)
      raw_ff <= filt_data;
  end

  // ==========================================================
  // Temperature-scaled gain: g*(1 + lin*dT/2^16 + quad*dT^2/2^24);
  // worked in 64 bits and clipped before narrowing, as the quadratic
  // term alone can pass 32 bits at extreme settings
  always_comb
  begin
    tdelta = 64'(sx16(temp_delta_i));
    gbase = 64'(sx16(gain_ff));
    lin_term = (gbase * 64'(sx16(lin_tc_ff)) * tdelta) >>> 16;
    quad_term = (gbase * 64'(sx16(quad_tc_ff)) * tdelta * tdelta) >>> 24;
    gscaled = gbase + lin_term + quad_term;
    // Clip to the -4..4 gain span before narrowing to 16 bits
    if (gscaled > 64'sd8192)
      gscaled = 64'sd8192;
    else if (gscaled < -64'sd8192)
      gscaled = -64'sd8192;
    nxt_eff_gain = gscaled[15:0];
  end

  // Effective gain register, one cycle behind the coefficients
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      eff_gain_ff <= `FSC_GAIN_RST;
    else
      eff_gain_ff <= nxt_eff_gain;
  end

  // Multiply stage; product scaled so 2048 counts x gain one = 4096
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prod_ff <= '0;
      prod_valid_ff <= 1'b0;
    end
    else
    begin
      prod_valid_ff <= filt_valid;
      if (filt_valid)
        prod_ff <= (32'(filt_data) * 32'(eff_gain_ff)) >>> 10;
    end
  end

  // Add, cap negative offset, clamp; 32-bit math cannot wrap here
  always_comb
  begin
    sum = sat_to(prod_ff + sx16(qol_ff), -32'sd65536, 32'sd65535);
    upper = sx16(ceil_ff);
    if (sx16(qol_ff) < 0 && sx16(qol_ff) + 32'sd4096 < upper)
      upper = sx16(qol_ff) + 32'sd4096;
    lower = sx16(floor_ff);
    nxt_out = sat_to(sat_to(sum, lower, upper), 32'sd0, 32'sd4095);
  end

  // Output register toward the DAC
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dac_code_o <= 12'h000;
      dac_enable_o <= 1'b0;
    end
    else
    begin
      dac_enable_o <= !busy_ff && !cmd_take;
      if (prod_valid_ff)
        dac_code_o <= nxt_out[11:0];
    end
  end

  // Span select and lock flag, registered for the pins; ready lags
  // the FIFO by one cycle, harmless while the filter drains each cycle
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      span_sel_o <= 3'h0;
      locked_o <= 1'b0;
      adc_ready_o <= 1'b0;
    end
    else
    begin
      span_sel_o <= mode_ff[`FSC_MODE_SPAN_LSB +: 3];
      locked_o <= guard_ff;
      adc_ready_o <= fifo_ready;
    end
  end
endmodule
`default_nettype wire

// ### verilog/fsc_params.svh
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH
// ==========================================================
// Register addresses on the command port
`define FSC_ADDR_MODE 4'h0
`define FSC_ADDR_LIN_TC 4'h1
`define FSC_ADDR_QUAD_TC 4'h2
`define FSC_ADDR_GAIN 4'h3
`define FSC_ADDR_QOL 4'h4
`define FSC_ADDR_FLOOR 4'h5
`define FSC_ADDR_CEIL 4'h6
`define FSC_ADDR_GUARD 4'h7
`define FSC_ADDR_RAW 4'h8
// ==========================================================
// Mode register field positions
`define FSC_MODE_SPAN_LSB 0
`define FSC_MODE_CORNER_LSB 3
// ==========================================================
// Reset values of the parameter registers
`define FSC_MODE_RST 6'h00
`define FSC_LIN_TC_RST 16'h0000
`define FSC_QUAD_TC_RST 16'h0000
`define FSC_GAIN_RST 16'h0800
`define FSC_QOL_RST 16'h0000
`define FSC_FLOOR_RST 16'h0000
`define FSC_CEIL_RST 16'h0fff
// ==========================================================
// Scaling: gain 1.0 is 2048, one supply span is 4096 output codes
`define FSC_GAIN_ONE 2048
`define FSC_SAMPLE_SPAN 2048
`define FSC_OUT_MAX 12'hfff
`define FSC_FLOOR_MAX 16'h0800
`endif

// ### verilog/fsc_pkg.sv
package fsc_pkg;
  typedef enum logic [2:0] {
    FSC_CORNER_80HZ,
    FSC_CORNER_160HZ,
    FSC_CORNER_500HZ,
    FSC_CORNER_1KHZ,
    FSC_CORNER_2KHZ,
    FSC_CORNER_RSV5,
    FSC_CORNER_RSV6,
    FSC_CORNER_RSV7
  } fsc_corner_t;
  typedef enum logic [1:0] {
    FSC_CMD_NONE,
    FSC_CMD_READ,
    FSC_CMD_WRITE,
    FSC_CMD_SEAL
  } fsc_cmd_t;
endpackage

// ### verilog/fsc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module fsc_fifo
  import fsc_pkg::*;
#(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
)(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;
  // ==========================================================
  // Handshakes; full refuses pushes so the source stalls
  assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr_ff];
  // Storage needs no reset
  always_ff @(posedge core_clk_i)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data_i;
  end
  // Pointers and fill level
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      if (push && !pop)
        count_ff <= count_ff + 1'b1;
      else if (pop && !push)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### verilog/fsc_lowpass.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
module fsc_lowpass
  import fsc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] corner_i,
  input wire logic in_valid_i,
  input wire logic signed [13:0] in_data_i,
  output logic out_valid_o,
  output logic signed [13:0] out_data_o
);
  logic signed [23:0] acc_ff;
  logic [3:0] shift;
  logic signed [23:0] sample_ext;
  logic signed [24:0] diff;
  logic signed [24:0] step;
  // ==========================================================
  // Corner to smoothing shift; larger shift is a lower corner
  always_comb
  begin
    unique case (fsc_corner_t'(corner_i))
      FSC_CORNER_80HZ: shift = 4'h6;
      FSC_CORNER_160HZ: shift = 4'h5;
      FSC_CORNER_500HZ: shift = 4'h3;
      FSC_CORNER_1KHZ: shift = 4'h2;
      FSC_CORNER_2KHZ: shift = 4'h1;
      default: shift = 4'h1;
    endcase
  end
  assign sample_ext = {in_data_i, 10'h000};
  // One bit wider so a full-scale swing cannot wrap the difference
  assign diff = 25'(sample_ext) - 25'(acc_ff);
  // Rising steps round up, else the output would stall one code low
  always_comb
  begin
    if (diff > 0)
      step = (diff + ((25'sd1 <<< shift) - 25'sd1)) >>> shift;
    else
      step = diff >>> shift;
  end
  // First-order IIR; acc holds the sample scaled by 1024
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      acc_ff <= '0;
      out_valid_o <= 1'b0;
    end
    else
    begin
      out_valid_o <= in_valid_i;
      if (in_valid_i)
        acc_ff <= 24'(25'(acc_ff) + step);
    end
  end
  assign out_data_o = acc_ff[23:10];
endmodule
`default_nettype wire

// ### verification/fsc_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
// ==========================================
// Command, lock and output-enable checks
module fsc_checker
  import fsc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] cmd_i,
  input wire logic [3:0] cmd_addr_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic [15:0] cmd_rdata_o,
  input wire logic cmd_ack_o,
  input wire logic [2:0] span_sel_o,
  input wire logic dac_enable_o,
  input wire logic locked_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // A command only counts while the guard is clear
  logic taken;
  logic mode_wr;
  logic rd_cmd;
  assign taken = (cmd_i != 2'h0) && !locked_o;
  assign rd_cmd = taken && (cmd_i == FSC_CMD_READ);
  assign mode_wr = taken && (cmd_i == FSC_CMD_WRITE)
    && (cmd_addr_i == `FSC_ADDR_MODE);
  sequence out_quiet;
    !dac_enable_o [*2];
  endsequence
  ack_after_cmd_a: assert property (taken |=> cmd_ack_o)
    else $error("command not acknowledged");
  ack_has_cause_a: assert property (cmd_ack_o |-> $past(taken))
    else $error("ack without accepted command");
  dac_off_cmd_a: assert property (taken |=> out_quiet)
    else $error("analog output not off during exchange");
  span_hold_a: assert property (!mode_wr && !$past(mode_wr) |=>
    $stable(span_sel_o))
    else $error("span changed without mode write");
  span_write_a: assert property (mode_wr |=> ##1
    span_sel_o == $past(cmd_wdata_i[2:0], 2))
    else $error("span not taken from mode bits");
  rdata_hold_a: assert property (!rd_cmd |=> $stable(cmd_rdata_o))
    else $error("read data moved without read");
  guard_sticky_a: assert property (locked_o |=> locked_o)
    else $error("guard cleared");
  seal_locks_a: assert property (taken && cmd_i == FSC_CMD_SEAL
    |=> ##1 locked_o)
    else $error("seal did not lock");
endmodule
bind fsc_dsp fsc_checker i_chk (
  .core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i),
  .cmd_i(cmd_i),
  .cmd_addr_i(cmd_addr_i),
  .cmd_wdata_i(cmd_wdata_i),
  .cmd_rdata_o(cmd_rdata_o),
  .cmd_ack_o(cmd_ack_o),
  .span_sel_o(span_sel_o),
  .dac_enable_o(dac_enable_o),
  .locked_o(locked_o)
);
`default_nettype wire

// ### verification/fsc_programmer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// External programmer on the supply-modulation side
module fsc_programmer (
  input wire logic core_clk_i,
  output logic [1:0] cmd_o,
  output logic [3:0] addr_o,
  output logic [15:0] wdata_o
);
  initial
  begin
    cmd_o = 2'h0;
    addr_o = 4'h0;
    wdata_o = 16'h0;
  end
  // Request held over its sampling edge; released lines show junk
  task automatic xfer(input logic [1:0] c, input logic [3:0] a,
    input logic [15:0] d);
    @(posedge core_clk_i);
    cmd_o <= c;
    addr_o <= a;
    wdata_o <= d;
    @(posedge core_clk_i);
    cmd_o <= 2'h0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // Two-point fit in output codes, 4096 codes per supply span
  task automatic calib(input int r1, r2, v1, v2, output int g, q);
    g = (v1 - v2) * 1024 / (r1 - r2);
    q = v1 - r1 * g / 1024;
  endtask
endmodule
`default_nettype wire

// ### verification/test_field_sensor_conditioning_dsp.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
`define CHK(n, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("BAD %s exp %0h got %0h", n, e, g); \
    end \
  end
module test_field_sensor_conditioning_dsp
  import fsc_pkg::*;
;
  logic clk;
  logic rst_n;
  logic vld;
  logic rdy;
  logic [13:0] smp;
  logic [15:0] temp;
  logic [1:0] cmd;
  logic [3:0] addr;
  logic [15:0] wdat;
  logic [15:0] rdat;
  logic ack;
  logic [2:0] span;
  logic [11:0] dac;
  logic en;
  logic lock;
  logic got_ack;
  logic [15:0] got_rd;
  logic [31:0] seed;
  int fail_count;
  int tests_run;
  logic [15:0] rstv [8] = '{16'h0, 16'h0, 16'h0, 16'h0800,
    16'h0, 16'h0, 16'h0fff, 16'h0};
  // gain, level, floor, ceiling, sample
  int tc [6][5] = '{'{2048, 2048, 0, 4095, 512},
    '{-2048, 2048, 0, 4095, 512}, '{2048, -1000, 0, 4095, 2100},
    '{2048, 0, 512, 3072, -100}, '{2048, 1024, 512, 3072, 1900},
    '{8192, 0, 0, 4095, 8000}};
  fsc_programmer i_prog (
    .core_clk_i(clk),
    .cmd_o(cmd),
    .addr_o(addr),
    .wdata_o(wdat)
  );
  fsc_dsp i_dut (
    .core_clk_i(clk),
    .reset_n_i(rst_n),
    .adc_valid_i(vld),
    .adc_ready_o(rdy),
    .adc_data_i(smp),
    .temp_delta_i(temp),
    .cmd_i(cmd),
    .cmd_addr_i(addr),
    .cmd_wdata_i(wdat),
    .cmd_rdata_o(rdat),
    .cmd_ack_o(ack),
    .span_sel_o(span),
    .dac_code_o(dac),
    .dac_enable_o(en),
    .locked_o(lock)
  );
  // ==========================================
  // Reference model and helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Multiply, add level, then clamp; wide ints so nothing wraps
  function automatic int model(int s, int g, int q, int f, int c);
    int v;
    int hi;
    v = s * g / 1024 + q;
    hi = (q + 4096 < c) ? q + 4096 : c;
    if (hi > 4095) hi = 4095;
    if (v > hi) v = hi;
    if (v < f) v = f;
    if (v < 0) v = 0;
    return v;
  endfunction
  task automatic op(input logic [1:0] c, input logic [3:0] a,
    input logic [15:0] d);
    i_prog.xfer(c, a, d);
    @(posedge clk);
    got_ack = ack;
    got_rd = rdat;
  endtask
  task automatic setp(input int g, q, f, c);
    op(FSC_CMD_WRITE, `FSC_ADDR_GAIN, g[15:0]);
    op(FSC_CMD_WRITE, `FSC_ADDR_QOL, q[15:0]);
    op(FSC_CMD_WRITE, `FSC_ADDR_FLOOR, f[15:0]);
    op(FSC_CMD_WRITE, `FSC_ADDR_CEIL, c[15:0]);
  endtask
  // Poll under a bound, then let the filter finish so raw is exact
  task automatic settle(input int s, input int e);
    int n;
    smp <= s[13:0];
    for (n = 0; n < 4000 && dac !== e[11:0]; n++) @(posedge clk);
    if (n >= 4000)
    begin
      fail_count++;
      $display("BAD settle exp %0h got %0h", e[11:0], dac);
      end_sim();
    end
    else
    begin
      repeat (64) @(posedge clk);
      `CHK("dac", e[11:0], dac)
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #2500000;
    fail_count++;
    $display("BAD watchdog exp done got hang");
    end_sim();
  end
  // ==========================================
  // Main sequence
  initial
  begin
    logic [31:0] r;
    int r1;
    int g;
    int q;
    seed = 32'h1f30e83e;
    fail_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    vld = 1'b0;
    smp = 14'h0;
    temp = 16'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    vld <= 1'b1;
    foreach (rstv[i])
    begin
      op(FSC_CMD_READ, i[3:0], 16'h0);
      `CHK("reset value", rstv[i], got_rd)
    end
    // Each named corner code, 80 Hz to 2 kHz, random span bits; ends on 2 kHz
    for (int k = 0; k < 5; k++)
    begin
      r = rnd();
      op(FSC_CMD_WRITE, `FSC_ADDR_MODE, {10'h0, k[2:0], r[2:0]});
      op(FSC_CMD_READ, `FSC_ADDR_MODE, 16'h0);
      `CHK("span", r[2:0], span)
      `CHK("mode", {10'h0, k[2:0], r[2:0]}, got_rd)
    end
    // Shared settings first; coefficients restored to zero after
    for (int a = 1; a < 3; a++)
    begin
      r = rnd();
      op(FSC_CMD_WRITE, a[3:0], r[15:0]);
      op(FSC_CMD_READ, a[3:0], 16'h0);
      `CHK("temp coeff", r[15:0], got_rd)
      op(FSC_CMD_WRITE, a[3:0], 16'h0);
    end
    foreach (tc[i])
    begin
      setp(tc[i][0], tc[i][1], tc[i][2], tc[i][3]);
      settle(tc[i][4], model(tc[i][4], tc[i][0], tc[i][1], tc[i][2],
        tc[i][3]));
      op(FSC_CMD_READ, `FSC_ADDR_RAW, 16'h0);
      `CHK("raw", tc[i][4][13:0], got_rd[13:0])
    end
    // Drift: dT 256 with linear coefficient -128 halves the gain
    temp <= 16'h0100;
    op(FSC_CMD_WRITE, `FSC_ADDR_LIN_TC, 16'hff80);
    settle(300, model(300, 4096, 0, 0, 4095));
    temp <= 16'h0000;
    op(FSC_CMD_WRITE, `FSC_ADDR_LIN_TC, 16'h0000);
    // Two-point fit, targets inside limits and 3000 codes apart
    settle(-500, 0);
    op(FSC_CMD_READ, `FSC_ADDR_RAW, 16'h0);
    r1 = $signed(got_rd[13:0]);
    settle(1500, 4095);
    op(FSC_CMD_READ, `FSC_ADDR_RAW, 16'h0);
    i_prog.calib(r1, $signed(got_rd[13:0]), 3500, 500, g, q);
    setp(g, q, 0, 4095);
    settle(1500, 500);
    settle(-500, 3500);
    op(FSC_CMD_WRITE, `FSC_ADDR_GUARD, 16'h0);
    `CHK("guard", 1'b0, lock)
    op(FSC_CMD_SEAL, 4'h0, 16'h0);
    `CHK("seal ack", 1'b1, got_ack)
    op(FSC_CMD_WRITE, `FSC_ADDR_GAIN, 16'h0);
    `CHK("locked", 1'b1, lock)
    `CHK("write locked", 1'b0, got_ack)
    op(FSC_CMD_READ, `FSC_ADDR_GAIN, 16'h0);
    `CHK("read locked", 1'b0, got_ack)
    repeat (20) @(posedge clk);
    `CHK("dac kept", 12'd3500, dac)
    `CHK("still locked", 1'b1, lock)
    `CHK("dac enable", 1'b1, en)
    `CHK("ready", 1'b1, rdy)
    end_sim();
  end
endmodule
`default_nettype wire
